// File: hw/ckd_pkg.sv
package ckd_pkg;
	// key counts
	localparam int NKEYS = 7;
	localparam int NOUT = 5;

	// clock rate and times in milliseconds
	localparam int CLK_HZ = 20000000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int BASE_MS = 8;
	localparam int CHG_MS = 100;
	localparam int SRST_MS = 125;
	localparam int NACK_MS = 30;

	// times as clock cycles
	localparam int BASE_CYC = BASE_MS * CYC_PER_MS;
	localparam int CHG_CYC = CHG_MS * CYC_PER_MS;
	localparam int SRST_CYC = SRST_MS * CYC_PER_MS;
	localparam int NACK_CYC = NACK_MS * CYC_PER_MS;

	// register byte offsets
	localparam logic [7:0] A_DSTAT = 8'h00;
	localparam logic [7:0] A_KSTAT = 8'h04;
	localparam logic [7:0] A_CAL = 8'h08;
	localparam logic [7:0] A_SRST = 8'h0c;
	localparam logic [7:0] A_INTV = 8'h10;
	localparam logic [7:0] A_GUARD = 8'h14;
	localparam logic [7:0] A_DI = 8'h18;
	localparam logic [7:0] A_AVE_LO = 8'h1c;
	localparam logic [7:0] A_AVE_HI = 8'h20;
	localparam logic [7:0] A_THR_LO = 8'h24;
	localparam logic [7:0] A_THR_HI = 8'h28;
	localparam logic [7:0] A_GRP = 8'h2c;

	// detection status bit positions
	localparam int DS_TOUCH = 0;
	localparam int DS_OVF = 6;
	localparam int DS_CAL = 7;

	// values after reset in serial mode
	localparam logic [7:0] R_INTV = 8'h01;
	localparam logic [7:0] R_DI = 8'h04;
	localparam logic [7:0] R_AVE = 8'h08;
	localparam logic [7:0] R_THR = 8'h14;
	localparam logic [2:0] R_GUARD = 3'h7;

	// fixed standalone settings
	localparam logic [7:0] SA_AVE_GUARD = 8'h10;
	localparam logic [7:0] SA_AVE_KEY = 8'h08;
	localparam logic [7:0] SA_THR_GUARD = 8'h0a;
	localparam logic [7:0] SA_THR_KEY = 8'h14;
	localparam logic [7:0] SA_DI = 8'h04;
	localparam logic [7:0] SA_INTV = 8'h01;
	localparam logic [2:0] SA_GUARD = 3'h0;

	// integrator floor
	localparam logic [7:0] DI_MIN = 8'h02;

	// strap capture delay after pin reset
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_RUN = 2'b01,
		ST_WDOG = 2'b10
	} ckd_state_t;
endpackage

// File: hw/ckd_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ckd_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// level from outside, level in clock domain
	input wire logic d,
	output logic q
);
	logic meta_r;
	logic q_r;

	// two flops, the first read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			q_r <= 1'b0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule
`default_nettype wire

// File: hw/ckd_key.sv
`timescale 1ns/1ns
`default_nettype none
module ckd_key (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// calibration clears the key
	input wire logic cal,
	// one sample per acquisition
	input wire logic smp,
	input wire logic over,
	input wire logic block,
	input wire logic [7:0] lim,
	// key state
	output logic det,
	output logic integ
);
	logic det_r;
	logic [7:0] cnt_r;
	logic flip;
	logic [7:0] cnt_inc;

	// a sample confirms a change when it disagrees with the state and, for entering detect, block is low
	assign flip = det_r ? !over : (over && !block);
	assign cnt_inc = cnt_r + 8'h01;

	// integrator counts consecutive confirming samples, both directions
	always_ff @(posedge clk) begin
		if (rst || cal) begin
			det_r <= 1'b0;
			cnt_r <= 8'h00;
		end else if (smp) begin
			if (!flip) begin
				cnt_r <= 8'h00;
			end else if (cnt_inc >= lim) begin // RULE23
				det_r <= !det_r;
				cnt_r <= 8'h00;
			end else begin
				cnt_r <= cnt_inc;
			end
		end
	end

	assign det = det_r;
	assign integ = cnt_r != 8'h00;

	// entering detect always follows an earlier confirming sample
	chk_key_two_samples: assert property ( // RULE23
		@(posedge clk) disable iff (rst) $rose(det_r) |-> $past(cnt_r) != 8'h00)
		else $error("key entered detect on a single sample");
endmodule
`default_nettype wire

// File: hw/ckd_ctrl.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// (RULE1) strap high at power-up selects standalone
// (RULE2) standalone settings fixed, writes refused
// (RULE3) standalone: per-key pins, key 0 guard
// (RULE4) seven keys serial, guard plus four standalone
// (RULE5) zero averaging factor disables a key
// (RULE6) key pins only in standalone, open-drain
// (RULE7) 8 ms base cycle, interval in cycles
// (RULE8) calibrate, touch, integrating: every cycle
// (RULE9) host avoids intervals above 32 cycles
// (RULE10) one detect per lockout group; keys of a group confirming on the same sample all enter detect
// (RULE11) change low on status change, read releases
// (RULE12) status returned: any read releases
// (RULE13) change low 100 ms after reset
// (RULE14) bus access wakes the device
// (RULE15) soft reset write: reset 125 ms later
// (RULE16) refuse bus transfers first 30 ms
// (RULE17) calibration write recalibrates all keys
// (RULE18) calibrate clears key and overflow bits
// (RULE19) one guard, key 0 or host-chosen
// (RULE20) guard filtering resets normal key filters
// (RULE21) guard detect suppresses other key outputs
// (RULE22) standalone guard: factor 16, threshold 10
// (RULE23) integrator needs two samples at least
// (RULE24) standalone thresholds 10 guard, 20 others
// (RULE25) key pin pulls low while in detect
module ckd_ctrl #(
	parameter int BASE_CYC_P = ckd_pkg::BASE_CYC,
	parameter int CHG_CYC_P = ckd_pkg::CHG_CYC,
	parameter int SRST_CYC_P = ckd_pkg::SRST_CYC,
	parameter int NACK_CYC_P = ckd_pkg::NACK_CYC
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// mode strap pin
	input wire logic MODE_PIN,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// acquisition front end
	output logic ACQ_REQ,
	output logic CAL_REQ,
	output logic [ckd_pkg::NKEYS-1:0] ACQ_KEYS,
	output logic [ckd_pkg::NKEYS*8-1:0] AVE_FACTOR,
	output logic AWAKE,
	input wire logic ACQ_DONE,
	input wire logic [ckd_pkg::NKEYS*8-1:0] KEY_DELTA,
	input wire logic ACQ_OVF,
	// open-drain pins
	output logic CHANGE_N_O,
	output logic CHANGE_N_OE,
	output logic [ckd_pkg::NOUT-1:0] KEY_OUT_O,
	output logic [ckd_pkg::NOUT-1:0] KEY_OUT_OE,
	// mode seen at start-up
	output logic STANDALONE
);
	localparam int NK = ckd_pkg::NKEYS;
	localparam logic [21:0] BASE_END = 22'(BASE_CYC_P - 1);
	localparam logic [21:0] CHG_END = 22'(CHG_CYC_P - 1);
	localparam logic [21:0] BOOT_PRE = 22'(CHG_CYC_P - 2);
	localparam logic [21:0] SRST_END = 22'(SRST_CYC_P - 1);
	localparam logic [21:0] NACK_END = 22'(NACK_CYC_P - 1);

	ckd_pkg::ckd_state_t state_r, state_nxt;
	logic [21:0] tmr_r, wd_r, base_r;
	logic [1:0] strap_cnt_r;
	logic mode_s, standalone_r;
	logic [7:0] intv_r, di_r, intv_cnt_r;
	logic [2:0] guard_r;
	logic [NK*8-1:0] ave_r, thr_r, ave_e, thr_e;
	logic [NK*2-1:0] grp_r;
	logic [NK-1:0] en, over, blk, det, integ, gmask, rep;
	logic calib_r, cal_sent_r, busy_r, acq_req_r, due_pend_r, ovf_r, wake_r;
	logic chg_r;
	logic [15:0] prev_r, seen_r;
	logic [31:0] prdata_r, rd_val;
	logic [NK-1:0] out_oe_r;
	logic [7:0] dstat;

	// internal reset: pin reset or watchdog expiry
	wire wd_fire = (state_r == ckd_pkg::ST_WDOG) && (wd_r == SRST_END);
	wire rst_i = SRST || wd_fire; // RULE15

	// strap pin enters the clock domain
	ckd_sync u_mode_sync (
		.clk(REF_CLK),
		.rst(SRST),
		.d(MODE_PIN),
		.q(mode_s)
	);

	// strap caught once after the pin reset, not after soft reset
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			strap_cnt_r <= 2'h0;
			standalone_r <= 1'b0;
		end else if (strap_cnt_r != ckd_pkg::STRAP_WAIT + 2'h1) begin
			// counter parks one past the capture point, so the strap is never read again
			if (strap_cnt_r == ckd_pkg::STRAP_WAIT) begin
				standalone_r <= mode_s; // RULE1
			end
			strap_cnt_r <= strap_cnt_r + 2'h1;
		end
	end

	// time since the last reset, stops at the change-line deadline
	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			tmr_r <= 22'h0;
		end else if (tmr_r != CHG_END) begin
			tmr_r <= tmr_r + 22'h1;
		end
	end

	wire boot_ev = tmr_r == BOOT_PRE;
	wire boot_done = tmr_r == CHG_END;
	wire nack = state_r == ckd_pkg::ST_INIT;

	// apb decode
	wire setup = PSEL && !PENABLE;
	wire acc = PSEL && PENABLE;
	wire a_dstat = PADDR == ckd_pkg::A_DSTAT;
	wire a_kstat = PADDR == ckd_pkg::A_KSTAT;
	wire a_cal = PADDR == ckd_pkg::A_CAL;
	wire a_srst = PADDR == ckd_pkg::A_SRST;
	wire a_intv = PADDR == ckd_pkg::A_INTV;
	wire a_guard = PADDR == ckd_pkg::A_GUARD;
	wire a_di = PADDR == ckd_pkg::A_DI;
	wire a_ave_lo = PADDR == ckd_pkg::A_AVE_LO;
	wire a_ave_hi = PADDR == ckd_pkg::A_AVE_HI;
	wire a_thr_lo = PADDR == ckd_pkg::A_THR_LO;
	wire a_thr_hi = PADDR == ckd_pkg::A_THR_HI;
	wire a_grp = PADDR == ckd_pkg::A_GRP;
	wire mapped = a_dstat || a_kstat || a_cal || a_srst || a_intv || a_guard || a_di
		|| a_ave_lo || a_ave_hi || a_thr_lo || a_thr_hi || a_grp;
	wire refuse = nack || !mapped || (PWRITE && standalone_r); // RULE16 RULE2
	wire wr = acc && PWRITE && !refuse;
	wire rd = acc && !PWRITE && !refuse;
	wire nz = PWDATA[7:0] != 8'h00;
	wire cal_wr = wr && a_cal && nz; // RULE17
	wire srst_wr = wr && a_srst && nz; // RULE15
	wire rd_stat = rd && (a_dstat || a_kstat);

	// zero wait states; refusals answered with an error
	assign PREADY = acc;
	assign PSLVERR = acc && refuse; // RULE16
	assign PRDATA = prdata_r;

	// reset window, run, and watchdog wait after soft reset
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ckd_pkg::ST_INIT: begin
				if (tmr_r == NACK_END) begin
					state_nxt = ckd_pkg::ST_RUN;
				end
			end
			ckd_pkg::ST_RUN: begin
				if (srst_wr) begin
					state_nxt = ckd_pkg::ST_WDOG;
				end
			end
			ckd_pkg::ST_WDOG: state_nxt = ckd_pkg::ST_WDOG;
			default: state_nxt = ckd_pkg::ST_INIT;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			state_r <= ckd_pkg::ST_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// watchdog counts only while waiting to reset
	always_ff @(posedge REF_CLK) begin
		if (rst_i || state_r != ckd_pkg::ST_WDOG) begin
			wd_r <= 22'h0;
		end else begin
			wd_r <= wd_r + 22'h1; // RULE15
		end
	end

	// host settings
	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			intv_r <= ckd_pkg::R_INTV;
			di_r <= ckd_pkg::R_DI;
			guard_r <= ckd_pkg::R_GUARD;
			ave_r <= {NK{ckd_pkg::R_AVE}};
			thr_r <= {NK{ckd_pkg::R_THR}};
			grp_r <= '0;
		end else if (wr) begin
			if (a_intv) intv_r <= PWDATA[7:0];
			if (a_di) di_r <= PWDATA[7:0];
			if (a_guard) guard_r <= PWDATA[2:0];
			if (a_ave_lo) ave_r[31:0] <= PWDATA;
			if (a_ave_hi) ave_r[NK*8-1:32] <= PWDATA[NK*8-33:0];
			if (a_thr_lo) thr_r[31:0] <= PWDATA;
			if (a_thr_hi) thr_r[NK*8-1:32] <= PWDATA[NK*8-33:0];
			if (a_grp) grp_r <= PWDATA[NK*2-1:0];
		end
	end

	// effective settings, fixed in standalone mode
	wire [2:0] guard_e = standalone_r ? ckd_pkg::SA_GUARD : guard_r; // RULE19 RULE3
	wire [7:0] di_e = standalone_r ? ckd_pkg::SA_DI :
		((di_r < ckd_pkg::DI_MIN) ? ckd_pkg::DI_MIN : di_r); // RULE23
	wire [7:0] intv_e = standalone_r ? ckd_pkg::SA_INTV :
		((intv_r == 8'h00) ? 8'h01 : intv_r); // RULE7

	// guard filtering in or in detect
	wire g_det = |(det & gmask);
	wire g_enter = |(gmask & ~det & (over | integ));

	// per-key thresholds, enables, lockout and integrator
	for (genvar k = 0; k < NK; k++) begin : g_key
		logic [NK-1:0] peer;
		wire is_g = guard_e == 3'(k);
		wire [7:0] sa_ave = (k == 0) ? ckd_pkg::SA_AVE_GUARD :
			((k < ckd_pkg::NOUT) ? ckd_pkg::SA_AVE_KEY : 8'h00); // RULE22 RULE4
		wire [7:0] sa_thr = (k == 0) ? ckd_pkg::SA_THR_GUARD : ckd_pkg::SA_THR_KEY; // RULE24
		wire [1:0] gk = standalone_r ? 2'b00 : grp_r[k*2 +: 2];
		assign gmask[k] = is_g;
		assign ave_e[k*8 +: 8] = standalone_r ? sa_ave : ave_r[k*8 +: 8];
		assign thr_e[k*8 +: 8] = standalone_r ? sa_thr : thr_r[k*8 +: 8];
		assign en[k] = ave_e[k*8 +: 8] != 8'h00; // RULE5
		assign over[k] = en[k] && (KEY_DELTA[k*8 +: 8] >= thr_e[k*8 +: 8]);
		for (genvar j = 0; j < NK; j++) begin : g_peer
			assign peer[j] = (j != k) && (gk != 2'b00) && (grp_r[j*2 +: 2] == gk);
		end
		assign blk[k] = |(det & peer) || (!is_g && g_enter); // RULE10 RULE20
		ckd_key u_key (
			.clk(REF_CLK),
			.rst(rst_i),
			.cal(calib_r || cal_wr), // RULE18
			.smp(ACQ_DONE && busy_r),
			.over(over[k]),
			.block(blk[k]),
			.lim(di_e),
			.det(det[k]),
			.integ(integ[k])
		);
	end

	// reported keys: guard detect hides the rest
	assign rep = g_det ? (det & en & gmask) : (det & en); // RULE21

	// base cycle timer
	always_ff @(posedge REF_CLK) begin
		if (rst_i || base_r == BASE_END) begin
			base_r <= 22'h0;
		end else begin
			base_r <= base_r + 22'h1;
		end
	end

	wire tick = base_r == BASE_END;
	wire fast = calib_r || (|det) || (|integ); // RULE8
	wire due_now = tick && (fast || (intv_cnt_r + 8'h01 >= intv_e)); // RULE7
	wire cal_go = calib_r && !cal_sent_r;
	wire acq_go = !busy_r && (cal_go || due_pend_r || due_now);
	wire smp = ACQ_DONE && busy_r;

	// interval count and pending acquisition
	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			intv_cnt_r <= 8'h00;
			due_pend_r <= 1'b0;
		end else begin
			if (tick) intv_cnt_r <= due_now ? 8'h00 : intv_cnt_r + 8'h01;
			due_pend_r <= (due_now || due_pend_r) && !acq_go;
		end
	end

	// acquisition handshake with the front end
	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			acq_req_r <= 1'b0;
		end else begin
			acq_req_r <= acq_go;
			busy_r <= acq_go || (busy_r && !ACQ_DONE);
		end
	end

	// calibration: requested at reset or by the host, ends after one acquisition
	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			calib_r <= 1'b1;
			cal_sent_r <= 1'b0;
		end else if (cal_wr) begin
			calib_r <= 1'b1; // RULE17
			cal_sent_r <= 1'b0;
		end else if (cal_go && acq_go) begin
			cal_sent_r <= 1'b1;
		end else if (smp && cal_sent_r) begin
			calib_r <= 1'b0;
			cal_sent_r <= 1'b0;
		end
	end

	// overflow held clear while calibrating, then taken per acquisition
	always_ff @(posedge REF_CLK) begin
		if (rst_i || calib_r || cal_wr) begin
			ovf_r <= 1'b0; // RULE18
		end else if (smp) begin
			ovf_r <= ACQ_OVF;
		end
	end

	// a bus access keeps the device awake to the next base cycle
	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= PSEL || (wake_r && !tick); // RULE14
		end
	end

	// detection status byte
	always_comb begin
		dstat = 8'h00;
		dstat[ckd_pkg::DS_TOUCH] = |rep;
		dstat[ckd_pkg::DS_OVF] = ovf_r;
		dstat[ckd_pkg::DS_CAL] = calib_r;
	end

	wire [7:0] kstat = {1'b0, rep};
	wire [15:0] stat = {dstat, kstat};
	wire stat_ev = boot_done && (stat != prev_r);
	wire rd_clr = rd_stat || (rd && stat == seen_r); // RULE11 RULE12

	// change flag: set wins over release
	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			chg_r <= 1'b0;
			prev_r <= 16'h0;
			seen_r <= 16'h0;
		end else begin
			prev_r <= stat;
			if (rd_stat) seen_r <= stat;
			chg_r <= stat_ev || boot_ev || (chg_r && !rd_clr); // RULE11 RULE13
		end
	end

	// read data and key pins from flops
	assign rd_val = a_dstat ? {24'h0, dstat} :
		a_kstat ? {24'h0, kstat} :
		a_intv ? {24'h0, intv_r} :
		a_guard ? {29'h0, guard_r} :
		a_di ? {24'h0, di_r} :
		a_ave_lo ? ave_r[31:0] :
		a_ave_hi ? {8'h0, ave_r[NK*8-1:32]} :
		a_thr_lo ? thr_r[31:0] :
		a_thr_hi ? {8'h0, thr_r[NK*8-1:32]} :
		a_grp ? {18'h0, grp_r} : 32'h0;

	always_ff @(posedge REF_CLK) begin
		if (rst_i) begin
			prdata_r <= 32'h0;
			out_oe_r <= '0;
		end else begin
			if (setup) prdata_r <= nack ? 32'h0 : rd_val;
			out_oe_r <= standalone_r ? rep : '0; // RULE6 RULE25 RULE3
		end
	end

	// outputs
	assign ACQ_REQ = acq_req_r;
	assign CAL_REQ = acq_req_r && cal_sent_r;
	assign ACQ_KEYS = en; // RULE5
	assign AVE_FACTOR = ave_e;
	assign AWAKE = busy_r || wake_r; // RULE14
	assign CHANGE_N_O = 1'b0;
	assign CHANGE_N_OE = chg_r && !standalone_r; // RULE11
	assign KEY_OUT_O = '0;
	assign KEY_OUT_OE = out_oe_r[ckd_pkg::NOUT-1:0]; // RULE25
	assign STANDALONE = standalone_r;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (rst_i);

	chk_chg_boot_pull: assert property (boot_ev |=> chg_r ##1 chg_r) // RULE13
		else $error("change flag not raised at start-up deadline");
	chk_nack_init_win: assert property (acc && nack |-> PSLVERR && PREADY) // RULE16
		else $error("transfer accepted during start-up window");
	chk_sa_write_lock: assert property (standalone_r && acc && PWRITE // RULE2
		|=> $stable(intv_r) && $stable(di_r) && $stable(guard_r) && $stable(grp_r))
		else $error("write accepted in standalone mode");
	chk_serial_pins_off: assert property (!standalone_r && !$past(standalone_r)
		|-> KEY_OUT_OE == '0) // RULE6
		else $error("key pin driven in serial mode");
	chk_guard_hides_keys: assert property (g_det |-> (rep & ~gmask) == '0) // RULE21
		else $error("normal key reported during guard detect");
	chk_cal_clears_stat: assert property (cal_wr |=> kstat == 8'h00 && !ovf_r) // RULE18
		else $error("status not cleared by calibration");
	chk_fast_acq_touch: assert property (tick && (|det) && !busy_r |=> ACQ_REQ) // RULE8
		else $error("no acquisition on base cycle while touched");
	chk_chg_held_low: assert property (chg_r && !rd |=> chg_r) // RULE12
		else $error("change flag dropped without a read");
endmodule
`default_nettype wire

// File: sim/ckd_fe_model.sv
`timescale 1ns/1ns
`default_nettype none
module ckd_fe_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request from the block
	input wire logic acq_req,
	// answer delay and values to return
	input wire logic [7:0] dly,
	input wire logic [55:0] delta_in,
	input wire logic ovf_in,
	// answer to the block
	output logic acq_done,
	output logic [55:0] key_delta,
	output logic acq_ovf
);
	logic busy;
	logic [7:0] cnt;
	logic [55:0] held = '0;
	logic ovf_h = 1'b0;
	// results mean something only in the done cycle, so show garbage otherwise
	assign key_delta = acq_done ? held : ~held;
	assign acq_ovf = acq_done ? ovf_h : ~ovf_h;
	// one acquisition at a time, answered dly+1 cycles after the request is taken
	always @(posedge clk) begin
		acq_done <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
		end else if (busy && cnt == 8'h00) begin
			busy <= 1'b0;
			acq_done <= 1'b1;
			held <= delta_in;
			ovf_h <= ovf_in;
		end else if (busy) begin
			cnt <= cnt - 8'h01;
		end else if (acq_req) begin
			busy <= 1'b1;
			cnt <= dly;
		end
	end
endmodule
`default_nettype wire

// File: sim/ckd_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ckd_ctrl_tb_top;
	// shortened counts
	localparam int BC = 20;
	localparam int CC = 400;
	localparam int SC = 300;
	localparam int NC = 100;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic mode = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] dly = 8'h03;
	logic [55:0] delta = '0;
	logic ovf = 1'b0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, acq_req, cal_req, acq_done, acq_ovf, change_oe, standalone;
	wire logic awake, change_o;
	wire logic [6:0] acq_keys;
	wire logic [55:0] ave_factor, key_delta;
	wire logic [4:0] key_out_oe, key_out_o;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int last = 0;
	int gap = 0;
	logic [31:0] rdat;
	logic rerr;

	// clock, cycle count since reset and spacing of acquisition requests
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= srst ? 0 : cyc + 1;
	always @(negedge ref_clk) begin
		if (acq_req === 1'b1) begin
			gap <= cyc - last;
			last <= cyc;
		end
	end

	ckd_ctrl #(.BASE_CYC_P(BC), .CHG_CYC_P(CC), .SRST_CYC_P(SC), .NACK_CYC_P(NC)) ckd_ctrl_i (
		.REF_CLK(ref_clk), .SRST(srst), .MODE_PIN(mode),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ACQ_REQ(acq_req), .CAL_REQ(cal_req), .ACQ_KEYS(acq_keys), .AVE_FACTOR(ave_factor),
		.AWAKE(awake), .ACQ_DONE(acq_done), .KEY_DELTA(key_delta), .ACQ_OVF(acq_ovf),
		.CHANGE_N_O(change_o), .CHANGE_N_OE(change_oe), .KEY_OUT_O(key_out_o),
		.KEY_OUT_OE(key_out_oe), .STANDALONE(standalone));
	ckd_fe_model ckd_fe_model_i (.clk(ref_clk), .rst(srst), .acq_req(acq_req), .dly(dly),
		.delta_in(delta), .ovf_in(ovf), .acq_done(acq_done), .key_delta(key_delta),
		.acq_ovf(acq_ovf));

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one transfer, held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) errors++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic er);
		rd(a);
		chk(nm, rdat, e);
		chk(nm, rerr, er);
	endtask
	task automatic touch(input int k, input logic [7:0] v);
		@(posedge ref_clk);
		delta[k*8 +: 8] <= v;
	endtask
	task automatic clr;
		@(posedge ref_clk);
		delta <= '0;
	endtask
	// settle a few edges, then stop where outputs are stable
	task automatic nap(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic wait_cyc(input int n);
		while (cyc < n) @(negedge ref_clk);
	endtask
	// wait for n requests or n answers, bounded
	task automatic wait_ev(input int n, input bit req);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(negedge ref_clk);
				k++;
			end while ((req ? acq_req : acq_done) !== 1'b1 && k < 3000);
			if (k >= 3000) errors++;
		end
		nap(3);
	endtask

	task automatic t_init;
		wait_cyc(5);
		rdc("early read", ckd_pkg::A_INTV, 32'h0, 1'b1);
		wait_cyc(NC + 2);
		rdc("interval", ckd_pkg::A_INTV, 32'h1, 1'b0);
		rdc("guard", ckd_pkg::A_GUARD, 32'h7, 1'b0);
		rdc("integrator", ckd_pkg::A_DI, 32'h4, 1'b0);
		rdc("averaging", ckd_pkg::A_AVE_LO, 32'h08080808, 1'b0);
		rd(8'h40);
		chk("unmapped", rerr, 1'b1);
		wait_cyc(CC - 20);
		chk("change early", change_oe, 1'b0);
		wait_cyc(CC + 5);
		chk("change after start", change_oe, 1'b1);
		chk("change level", change_o, 1'b0);
		chk("mode", standalone, 1'b0);
		rd(ckd_pkg::A_DSTAT);
		nap(2);
		chk("change released", change_oe, 1'b0);
	endtask
	task automatic t_det;
		wr(ckd_pkg::A_DI, 32'h0);
		wait_ev(1, 1'b0);
		touch(1, 8'h30);
		wait_ev(1, 1'b0);
		rdc("one sample", ckd_pkg::A_KSTAT, 32'h0, 1'b0);
		wait_ev(1, 1'b0);
		chk("change set", change_oe, 1'b1);
		rdc("two samples", ckd_pkg::A_KSTAT, 32'h2, 1'b0);
		nap(2);
		chk("change cleared", change_oe, 1'b0);
		touch(1, 8'h00);
		wait_ev(2, 1'b0);
		touch(1, 8'h30);
		wait_ev(2, 1'b0);
		chk("change held", change_oe, 1'b1);
		rd(ckd_pkg::A_INTV);
		nap(2);
		chk("any read clears", change_oe, 1'b0);
	endtask
	task automatic t_intv;
		touch(1, 8'h00);
		wr(ckd_pkg::A_INTV, 32'h3);
		wait_ev(5, 1'b1);
		chk("idle gap", gap, 3 * BC);
		touch(1, 8'h30);
		wait_ev(3, 1'b1);
		chk("touch gap", gap, BC);
		touch(1, 8'h00);
		wr(ckd_pkg::A_INTV, 32'h1);
		wait_ev(3, 1'b0);
	endtask
	task automatic t_lock;
		wr(ckd_pkg::A_GRP, 32'h14);
		touch(1, 8'h30);
		wait_ev(3, 1'b0);
		touch(2, 8'h30);
		wait_ev(3, 1'b0);
		rdc("lockout", ckd_pkg::A_KSTAT, 32'h2, 1'b0);
		touch(3, 8'h30);
		wait_ev(3, 1'b0);
		rdc("outside group", ckd_pkg::A_KSTAT, 32'ha, 1'b0);
		clr;
		wait_ev(3, 1'b0);
		wr(ckd_pkg::A_GRP, 32'h0);
	endtask
	task automatic t_guard;
		wr(ckd_pkg::A_GUARD, 32'h3);
		touch(1, 8'h30);
		touch(3, 8'h30);
		wait_ev(4, 1'b0);
		rdc("guard first", ckd_pkg::A_KSTAT, 32'h8, 1'b0);
	endtask
	task automatic t_cal;
		int k;
		ovf <= 1'b1;
		wait_ev(2, 1'b0);
		rd(ckd_pkg::A_DSTAT);
		chk("overflow", rdat & 32'h40, 32'h40);
		dly <= 8'd30;
		wr(ckd_pkg::A_CAL, 32'h1);
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (!(acq_req === 1'b1 && cal_req === 1'b1) && k < 200);
		chk("cal request", k < 200, 1'b1);
		rdc("cal keys", ckd_pkg::A_KSTAT, 32'h0, 1'b0);
		rd(ckd_pkg::A_DSTAT);
		chk("cal overflow", rdat & 32'h41, 32'h0);
		dly <= 8'h03;
		ovf <= 1'b0;
		clr;
		wr(ckd_pkg::A_GUARD, 32'h7);
		wait_ev(3, 1'b0);
	endtask
	task automatic t_dis;
		wr(ckd_pkg::A_AVE_LO, 32'h00080808);
		@(negedge ref_clk);
		chk("awake", awake, 1'b1);
		nap(2);
		chk("enabled keys", acq_keys, 7'h77);
		chk("factor off", ave_factor[31:24], 8'h00);
		wr(ckd_pkg::A_AVE_LO, 32'h08080808);
	endtask
	task automatic t_srst;
		wr(ckd_pkg::A_INTV, 32'h5);
		wr(ckd_pkg::A_SRST, 32'h1);
		repeat (SC - 40) @(posedge ref_clk);
		rdc("before watchdog", ckd_pkg::A_INTV, 32'h5, 1'b0);
		repeat (40) @(posedge ref_clk);
		rdc("after watchdog", ckd_pkg::A_INTV, 32'h0, 1'b1);
		repeat (NC + 10) @(posedge ref_clk);
		rdc("settings reset", ckd_pkg::A_INTV, 32'h1, 1'b0);
	endtask
	task automatic t_sa;
		clr;
		mode <= 1'b1;
		srst <= 1'b1;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		wait_cyc(NC + 5);
		chk("standalone", standalone, 1'b1);
		wr(ckd_pkg::A_INTV, 32'h2);
		chk("write refused", rerr, 1'b1);
		chk("keys", acq_keys, 7'h1f);
		chk("guard factor", ave_factor[7:0], 8'h10);
		chk("key factors", ave_factor[39:8], 32'h08080808);
		touch(2, 8'h18);
		touch(4, 8'h0c);
		wait_ev(6, 1'b0);
		chk("key pins", key_out_oe, 5'h04);
		chk("pin level", key_out_o, 5'h00);
		touch(0, 8'h0c);
		wait_ev(6, 1'b0);
		chk("guard pins", key_out_oe, 5'h01);
		wait_cyc(CC + 5);
		chk("no change line", change_oe, 1'b0);
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		t_init;
		t_det;
		t_intv;
		t_lock;
		t_guard;
		t_cal;
		t_dis;
		t_srst;
		t_sa;
		complete_run;
	end
	// cuts a hang short
	initial begin
		#1000000;
		errors++;
		complete_run;
	end
endmodule
`default_nettype wire
